//--- hw/ion_fault_ctrl.sv
`timescale 1ns/10ps
module ion_fault_ctrl #(
  parameter int DECI_CYCLES = ion_pkg::DECI_CYCLES // cycles per tenth second
) (
  input  wire logic              clk,          // system clock
  input  wire logic              resetn,       // synchronous reset, active low
  input  wire logic              hsel,         // slave select
  input  wire logic [1:0]        htrans,       // transfer type
  input  wire logic [31:0]       haddr,        // byte address
  input  wire logic              hwrite,       // write transfer
  input  wire logic [2:0]        hsize,        // transfer size
  input  wire logic [31:0]       hwdata,       // write data
  input  wire logic              hready,       // bus ready
  output logic                   hreadyout,    // slave ready
  output logic                   hresp,        // always okay
  output logic [31:0]            hrdata,       // read data
  input  wire logic              unitRun,      // main unit operating
  input  wire logic              fanRun,       // indoor fan turning
  input  wire logic [11:0]       fanRpm,       // indoor fan speed
  input  wire logic signed [7:0] intakeTemp,   // intake air, degrees C
  input  wire logic [2:0]        modeFan,      // fan speed of active mode
  input  wire logic [1:0]        modeSwing,    // swing of active mode
  input  wire logic              abnormalIn,   // generator abnormal pin
  input  ion_pkg::ion_mode_t     bootMode,     // mode kept across power loss
  output logic                   genPower,     // generator power switch
  output logic [2:0]             fanSel,       // fan speed request
  output logic [1:0]             swingSel,     // swing request
  output logic                   ionIndicator, // ionizer lamp
  output logic                   scheduleIndicatorBlink, // abnormal blink
  output logic                   beepShort,    // single beep pulse
  output logic                   beepLong,     // long beep pulse
  output logic                   unitStartReq, // start main unit pulse
  output logic                   unitStopReq,  // stop main unit pulse
  output ion_pkg::ion_mode_t     persistMode,  // mode to keep in storage
  output logic                   nvmWrite,     // store fault code pulse
  output logic                   nvmHidden,    // store to hidden area
  output logic [7:0]             ionizerFaultCode // code to store
);
  import ion_pkg::*;

  typedef struct packed {
    ion_mode_t   mode;
    ion_mode_t   savedMode;
    logic        booted;
    logic [1:0]  abnSync;
    logic        unitRunQ;
    logic        checkMode;
    logic [2:0]  remoteFan;
    logic [1:0]  remoteSwing;
    logic [2:0]  fanSel;
    logic [1:0]  swingSel;
    logic        genPower;
    logic [11:0] onSecs;
    logic [5:0]  abnRun;
    logic [11:0] backoff;
    logic [1:0]  discCnt;
    logic [3:0]  dischCnt;
    logic [11:0] okSecs;
    logic [8:0]  tempOk;
    logic        discFault;
    logic        ionIndicator;
    logic        blink;
    logic        beepShort;
    logic        beepLong;
    logic        unitStartReq;
    logic        unitStopReq;
    logic        nvmWrite;
    logic        nvmHidden;
    logic [7:0]  addrQ;
    logic        wrPend;
    logic        ready;
    logic [31:0] rdata;
  } ion_state_t;

  // temperature counter starts full so a cold start does not wait six minutes
  localparam ion_state_t RST = '{
    mode: M_OFF, savedMode: M_OFF, tempOk: TEMP_OK_S, ready: 1'b1, remoteFan: FAN_AUTO,
    default: '0
  };

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ion_state_t st;
  ion_state_t next_st;
  logic       deciTick;
  logic       secTick;
  logic       abn;
  logic       cmdIon;
  logic       cmdOn;
  logic       cmdOff;
  logic       inWin;
  logic       discEvt;
  logic       dischEvt;
  logic       stopping;
  logic       tempBad;
  logic [2:0] discNew;
  logic [4:0] dischNew;
  logic [1:0] discLim;

  ion_tick #(
    .DECI_CYCLES(DECI_CYCLES)
  ) u_tick (
    .clk     (clk),
    .resetn  (resetn),
    .deciTick(deciTick),
    .secTick (secTick)
  );

  always_comb begin
    next_st = st;
    next_st.beepShort = 1'b0;
    next_st.beepLong = 1'b0;
    next_st.unitStartReq = 1'b0;
    next_st.unitStopReq = 1'b0;
    next_st.nvmWrite = 1'b0;
    next_st.abnSync = {st.abnSync[0], abnormalIn};
    next_st.unitRunQ = unitRun;
    next_st.ready = 1'b1;
    abn = st.abnSync[1];

    // register writes land in the data phase
    cmdIon = st.wrPend && hit(st.addrQ, ADDR_CMD) && hwdata[CMD_ION];
    cmdOn = st.wrPend && hit(st.addrQ, ADDR_CMD) && hwdata[CMD_ON_TMR];
    cmdOff = st.wrPend && hit(st.addrQ, ADDR_CMD) && hwdata[CMD_OFF_TMR];
    if (st.wrPend && hit(st.addrQ, ADDR_CFG)) begin
      next_st.checkMode = hwdata[CFG_CHECK];
      next_st.remoteSwing = hwdata[CFG_SWING_LSB +: 2];
      // refused speeds leave the last accepted one in place
      if (hwdata[CFG_FAN_LSB +: 3] != FAN_POWERFUL &&
          hwdata[CFG_FAN_LSB +: 3] != FAN_QUIET) begin
        next_st.remoteFan = hwdata[CFG_FAN_LSB +: 3];
      end
    end
    next_st.wrPend = 1'b0;
    next_st.rdata = '0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      next_st.addrQ = haddr[7:0];
      next_st.wrPend = hwrite && hsize == HSIZE_WORD;
      if (!hwrite) begin
        if (hit(haddr[7:0], ADDR_CFG)) begin
          next_st.rdata = {26'h0, st.remoteSwing, st.remoteFan, st.checkMode};
        end else if (hit(haddr[7:0], ADDR_STAT)) begin
          next_st.rdata = {20'h0, st.blink, st.dischCnt, st.discCnt, st.discFault,
                           st.tempOk != TEMP_OK_S, st.genPower, st.mode};
        end
      end
    end

    // operating mode sequencing
    if (!st.booted) begin
      next_st.booted = 1'b1;
      next_st.mode = bootMode;
    end else if (cmdOff) begin
      if (st.mode != M_OFF || unitRun) begin
        next_st.savedMode = st.mode;
        next_st.mode = M_OFF;
        next_st.unitStopReq = 1'b1;
      end
    end else if (st.unitRunQ && !unitRun) begin
      next_st.mode = M_OFF;
    end else if (cmdOn) begin
      if (!unitRun && st.mode == M_OFF) begin
        next_st.mode = st.savedMode;
        next_st.unitStartReq = (st.savedMode != M_SOLO);
      end
    end else if (cmdIon) begin
      if (st.mode == M_OFF) begin
        next_st.mode = unitRun ? M_COMBO : M_SOLO;
      end else begin
        next_st.mode = M_OFF;
      end
    end else if (st.mode == M_SOLO && unitRun) begin
      next_st.mode = M_COMBO;
    end
    stopping = (st.mode != M_OFF) && (next_st.mode == M_OFF);
    if (next_st.mode != st.mode) begin
      if (st.mode == M_SOLO && next_st.mode == M_OFF) begin
        next_st.beepLong = 1'b1;
      end else begin
        next_st.beepShort = 1'b1;
      end
    end

    // fan and swing requests
    unique case (st.mode)
      M_OFF: begin
        next_st.fanSel = modeFan;
        next_st.swingSel = modeSwing;
      end
      M_COMBO: begin
        next_st.fanSel = modeFan;
        next_st.swingSel = modeSwing;
      end
      M_SOLO: begin
        next_st.fanSel = (st.remoteFan == FAN_AUTO) ? FAN_MED : st.remoteFan;
        next_st.swingSel = st.remoteSwing;
      end
    endcase

    // intake temperature guard band
    tempBad = (intakeTemp >= TEMP_HOT) || (intakeTemp <= TEMP_COLD);
    if (tempBad) begin
      next_st.tempOk = '0;
    end else if (secTick && st.tempOk != TEMP_OK_S) begin
      next_st.tempOk = st.tempOk + 9'h001;
    end

    // abnormal signal supervision
    inWin = (st.onSecs >= ARM_S) && (st.onSecs < WIN_END_S);
    discEvt = st.genPower && inWin && (st.abnRun >= DISC_HOLD_DS);
    dischEvt = st.genPower && (st.onSecs >= DISCH_ARM_S) &&
               (st.abnRun >= DISCH_HOLD_DS);
    if (!st.genPower) begin
      next_st.onSecs = '0;
    end else if (secTick && st.onSecs != DISCH_ARM_S) begin
      next_st.onSecs = st.onSecs + 12'h001;
    end
    // the run length only counts inside the two observation periods
    if (!abn || !st.genPower || st.onSecs < ARM_S ||
        (st.onSecs >= WIN_END_S && st.onSecs < DISCH_ARM_S)) begin
      next_st.abnRun = '0;
    end else if (deciTick && st.abnRun != 6'h3F) begin
      next_st.abnRun = st.abnRun + 6'h01;
    end

    if (discEvt) begin
      next_st.backoff = DISC_OFF_S;
      next_st.abnRun = '0;
    end else if (dischEvt) begin
      next_st.backoff = DISCH_OFF_S;
      next_st.abnRun = '0;
    end else if (secTick && st.backoff != 12'h000) begin
      next_st.backoff = st.backoff - 12'h001;
    end

    // disconnection counting and declaration
    discLim = st.checkMode ? DISC_LIM_CHECK : DISC_LIM_NORM;
    discNew = {1'b0, st.discCnt} + 3'h1;
    if (stopping && !st.checkMode) begin
      next_st.discCnt = '0;
    end
    if (discEvt) begin
      next_st.discCnt = (st.discCnt == 2'h3) ? st.discCnt : discNew[1:0];
      if (discNew >= {1'b0, discLim}) begin
        next_st.discFault = 1'b1;
        next_st.nvmWrite = 1'b1;
        next_st.nvmHidden = 1'b0;
        next_st.blink = st.blink || st.checkMode;
      end
    end

    // discharge counting and fault-free clearing
    dischNew = {1'b0, st.dischCnt} + 5'h01;
    if (dischEvt || next_st.mode == M_OFF) begin
      next_st.okSecs = '0;
    end else if (secTick) begin
      next_st.okSecs = st.okSecs + 12'h001;
    end
    if (stopping || (secTick && st.okSecs == DISCH_OK_S - 12'h001)) begin
      next_st.dischCnt = '0;
    end
    if (dischEvt) begin
      next_st.dischCnt = (st.dischCnt == 4'hF) ? st.dischCnt : dischNew[3:0];
      if (dischNew >= {1'b0, DISCH_LIM}) begin
        next_st.nvmWrite = 1'b1;
        next_st.nvmHidden = 1'b1;
      end
    end

    // generator enable
    next_st.genPower = (next_st.mode != M_OFF) && fanRun &&
                       (next_st.mode != M_COMBO || fanRpm >= RPM_MIN) &&
                       (next_st.tempOk == TEMP_OK_S) &&
                       (next_st.backoff == 12'h000) && !next_st.discFault;
    next_st.ionIndicator = (next_st.mode != M_OFF) && !next_st.discFault;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.ready;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign genPower = st.genPower;
  assign fanSel = st.fanSel;
  assign swingSel = st.swingSel;
  assign ionIndicator = st.ionIndicator;
  assign scheduleIndicatorBlink = st.blink;
  assign beepShort = st.beepShort;
  assign beepLong = st.beepLong;
  assign unitStartReq = st.unitStartReq;
  assign unitStopReq = st.unitStopReq;
  assign persistMode = st.mode;
  assign nvmWrite = st.nvmWrite;
  assign nvmHidden = st.nvmHidden;
  assign ionizerFaultCode = IONIZER_FAULT_CODE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_off_no_power;
    (next_st.mode == M_OFF) |=> !genPower && !ionIndicator;
  endproperty
  a_off_no_power: assert property (p_off_no_power)
    else $error("generator powered while ionizer off");

  property p_fan_stop;
    !fanRun |=> !genPower;
  endproperty
  a_fan_stop: assert property (p_fan_stop)
    else $error("generator on with fan stopped");

  property p_temp_pause;
    tempBad |=> !genPower [*2];
  endproperty
  a_temp_pause: assert property (p_temp_pause)
    else $error("generator on outside temperature band");

  property p_rpm_low;
    (next_st.mode == M_COMBO && fanRpm < RPM_MIN) |=> !genPower;
  endproperty
  a_rpm_low: assert property (p_rpm_low)
    else $error("generator on below minimum fan speed");

  property p_solo_fan;
    (st.mode == M_SOLO) |=> fanSel != FAN_POWERFUL && fanSel != FAN_QUIET && fanSel != FAN_AUTO;
  endproperty
  a_solo_fan: assert property (p_solo_fan)
    else $error("solo fan speed not resolved");

  property p_solo_swing;
    (st.mode == M_SOLO) |=> swingSel == $past(st.remoteSwing);
  endproperty
  a_solo_swing: assert property (p_solo_swing)
    else $error("solo swing not from remote setting");

  property p_off_timer;
    (st.booted && cmdOff && st.mode != M_OFF) |=> persistMode == M_OFF && unitStopReq
      && st.savedMode == $past(st.mode);
  endproperty
  a_off_timer: assert property (p_off_timer)
    else $error("off timer did not stop and save");

  property p_long_beep;
    (st.mode == M_SOLO && next_st.mode == M_OFF) |=> beepLong && !beepShort;
  endproperty
  a_long_beep: assert property (p_long_beep)
    else $error("solo stop without long beep");

  property p_disc_backoff;
    discEvt |=> st.backoff == DISC_OFF_S ##1 !genPower;
  endproperty
  a_disc_backoff: assert property (p_disc_backoff)
    else $error("disconnection backoff not loaded");

  property p_disc_clear;
    (stopping && !st.checkMode && !discEvt) |=> st.discCnt == 2'h0;
  endproperty
  a_disc_clear: assert property (p_disc_clear)
    else $error("disconnection count kept after stop");

  property p_check_declare;
    (discEvt && st.checkMode) |=> st.discFault && nvmWrite && !nvmHidden
      && scheduleIndicatorBlink ##1 !ionIndicator;
  endproperty
  a_check_declare: assert property (p_check_declare)
    else $error("check mode disconnection not declared");
endmodule : ion_fault_ctrl

//--- hw/ion_pkg.sv
package ion_pkg;
  // clock and tick timing
  localparam int CLK_HZ      = 200_000_000;
  localparam int DECI_MS     = 100;
  localparam int DECI_CYCLES = CLK_HZ / 1000 * DECI_MS;
  localparam logic [3:0] DECI_PER_SEC = 4'hA;

  // interval figures in their own units
  localparam int ARM_SEC        = 1;
  localparam int WIN_SEC        = 6;
  localparam int DISC_OFF_MIN   = 5;
  localparam int DISCH_ARM_MIN  = 30;
  localparam int DISCH_OFF_MIN  = 30;
  localparam int DISCH_OK_MIN   = 50;
  localparam int TEMP_OK_MIN    = 6;
  localparam logic [5:0] DISC_HOLD_DS  = 6'h3B; // 5.9 s in tenths
  localparam logic [5:0] DISCH_HOLD_DS = 6'h32; // 5 s in tenths

  localparam logic [11:0] ARM_S       = 12'(ARM_SEC);
  localparam logic [11:0] WIN_END_S   = 12'(ARM_SEC + WIN_SEC);
  localparam logic [11:0] DISC_OFF_S  = 12'(DISC_OFF_MIN * 60);
  localparam logic [11:0] DISCH_ARM_S = 12'(DISCH_ARM_MIN * 60);
  localparam logic [11:0] DISCH_OFF_S = 12'(DISCH_OFF_MIN * 60);
  localparam logic [11:0] DISCH_OK_S  = 12'(DISCH_OK_MIN * 60);
  localparam logic [8:0]  TEMP_OK_S   = 9'(TEMP_OK_MIN * 60);

  // thresholds
  localparam logic signed [7:0] TEMP_HOT  = 8'sh23;
  localparam logic signed [7:0] TEMP_COLD = 8'sh05;
  localparam logic [11:0] RPM_MIN        = 12'h168;
  localparam logic [1:0]  DISC_LIM_CHECK = 2'h1;
  localparam logic [1:0]  DISC_LIM_NORM  = 2'h3;
  localparam logic [3:0]  DISCH_LIM      = 4'hC;
  localparam logic [7:0]  IONIZER_FAULT_CODE = 8'h43; // value is arbitrary

  // fan speed codes
  localparam logic [2:0] FAN_AUTO     = 3'h0;
  localparam logic [2:0] FAN_MED      = 3'h3;
  localparam logic [2:0] FAN_POWERFUL = 3'h6;
  localparam logic [2:0] FAN_QUIET    = 3'h7;

  // register map and fields
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam int CMD_ION       = 0;
  localparam int CMD_ON_TMR    = 1;
  localparam int CMD_OFF_TMR   = 2;
  localparam int CFG_CHECK     = 0;
  localparam int CFG_FAN_LSB   = 1;
  localparam int CFG_SWING_LSB = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {M_OFF, M_COMBO, M_SOLO} ion_mode_t;
endpackage : ion_pkg

//--- hw/ion_tick.sv
`timescale 1ns/10ps
module ion_tick #(
  parameter int DECI_CYCLES = ion_pkg::DECI_CYCLES // cycles per tenth second
) (
  input  wire logic clk,      // system clock
  input  wire logic resetn,   // synchronous reset, active low
  output logic      deciTick, // one-cycle pulse every 0.1 s
  output logic      secTick   // one-cycle pulse every 1 s
);
  import ion_pkg::*;

  localparam int CW = $clog2(DECI_CYCLES);

  typedef struct packed {
    logic [CW-1:0] div;
    logic [3:0]    deci;
    logic          deciTick;
    logic          secTick;
  } ion_tick_t;

  ion_tick_t st;
  ion_tick_t next_st;

  always_comb begin
    next_st = st;
    next_st.deciTick = 1'b0;
    next_st.secTick = 1'b0;
    if (st.div == CW'(DECI_CYCLES - 1)) begin
      next_st.div = '0;
      next_st.deciTick = 1'b1;
      if (st.deci == DECI_PER_SEC - 4'h1) begin
        next_st.deci = 4'h0;
        next_st.secTick = 1'b1;
      end else begin
        next_st.deci = st.deci + 4'h1;
      end
    end else begin
      next_st.div = st.div + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign deciTick = st.deciTick;
  assign secTick = st.secTick;
endmodule : ion_tick

//--- tb/ion_fault_ctrl_tb.sv
`timescale 1ns/10ps
module ion_fault_ctrl_tb;
  import ion_pkg::*;
  localparam int DC  = 2;
  localparam int SEC = DC * 10;
  logic              clk, resetn, hsel, hwrite, hreadyout, hresp, unitRun, fanRun;
  logic              abnormalIn, breakWire, arcFault, genPower, ionIndicator, blink;
  logic              beepShort, beepLong, startReq, stopReq, nvmWrite, nvmHidden, lastHidden;
  logic [1:0]        htrans, modeSwing, swingSel;
  logic [2:0]        hsize, modeFan, fanSel;
  logic [31:0]       haddr, hwdata, hrdata, q;
  logic [11:0]       fanRpm;
  logic signed [7:0] intakeTemp;
  logic [7:0]        faultCode;
  ion_mode_t         bootMode, persistMode;
  int                n_mismatch, check_count;
  int                pc[5] = '{default: 0};
  int                pb[5];

  ion_fault_ctrl #(.DECI_CYCLES(DC)) dut (.clk(clk), .resetn(resetn), .hsel(hsel),
    .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .unitRun(unitRun), .fanRun(fanRun), .fanRpm(fanRpm), .intakeTemp(intakeTemp),
    .modeFan(modeFan), .modeSwing(modeSwing), .abnormalIn(abnormalIn), .bootMode(bootMode),
    .genPower(genPower), .fanSel(fanSel), .swingSel(swingSel), .ionIndicator(ionIndicator),
    .scheduleIndicatorBlink(blink), .beepShort(beepShort), .beepLong(beepLong),
    .unitStartReq(startReq), .unitStopReq(stopReq), .persistMode(persistMode),
    .nvmWrite(nvmWrite), .nvmHidden(nvmHidden), .ionizerFaultCode(faultCode));
  ion_gen_model gen (.genPower(genPower), .breakWire(breakWire), .arcFault(arcFault),
    .abnormalIn(abnormalIn));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses are counted so a scenario can compare deltas instead of exact cycles
  always @(posedge clk) begin
    if (beepShort === 1'b1) pc[0]++;
    if (beepLong === 1'b1) pc[1]++;
    if (startReq === 1'b1) pc[2]++;
    if (stopReq === 1'b1) pc[3]++;
    if (nvmWrite === 1'b1) pc[4]++;
    if (nvmWrite === 1'b1) lastHidden <= nvmHidden;
  end

  task report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task timeout(input string nm);
    n_mismatch++;
    $display("ERROR %s expected done seen timeout", nm);
    report_and_stop();
  endtask : timeout

  task edge_wait(input string nm);
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) timeout(nm);
      @(posedge clk);
    end
  endtask : edge_wait

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    edge_wait("address phase");
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_wait("data phase");
    q = hrdata;
  endtask : ahb

  task cmd(input logic [2:0] b);
    ahb(1'b1, ADDR_CMD, {29'h0, b});
    repeat (3) @(posedge clk);
  endtask : cmd

  task read_stat;
    ahb(1'b0, ADDR_STAT, 32'h0);
  endtask : read_stat

  task wait_gen(input logic v, input int s);
    int n;
    n = 0;
    while (genPower !== v) begin
      n++;
      if (n > s * SEC) timeout("genPower");
      @(posedge clk);
    end
    check("genPower", genPower, v);
  endtask : wait_gen

  task hold_gen(input logic v, input int s);
    logic bad;
    bad = 1'b0;
    repeat (s * SEC) begin
      @(posedge clk);
      if (genPower !== v) bad = 1'b1;
    end
    check("genPower hold", bad, 1'b0);
  endtask : hold_gen

  task rst(input ion_mode_t b);
    @(posedge clk);
    resetn   <= 1'b0;
    bootMode <= b;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst

  task t_regs;
    check("persistMode", persistMode, M_OFF);
    check("hresp", hresp, 1'b0);
    read_stat();
    check("stat", q, 32'h0);
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
    ahb(1'b1, ADDR_CFG, 32'h20);
    ahb(1'b1, ADDR_CFG, 32'h2E);
    ahb(1'b1, ADDR_CFG, 32'h2C);
    ahb(1'b0, ADDR_CFG, 32'h0);
    check("cfg", q, 32'h20);
  endtask : t_regs

  task t_solo;
    pb = pc;
    cmd(3'h1);
    read_stat();
    check("mode", q[1:0], M_SOLO);
    check("fanSel", fanSel, FAN_MED);
    check("swingSel", swingSel, 2'h2);
    check("beep", pc[0] - pb[0], 1);
    wait_gen(1'b1, 1);
    @(posedge clk) fanRun <= 1'b0;
    wait_gen(1'b0, 1);
    @(posedge clk) fanRun <= 1'b1;
    wait_gen(1'b1, 1);
    @(posedge clk) intakeTemp <= TEMP_COLD;
    wait_gen(1'b0, 1);
    @(posedge clk) intakeTemp <= TEMP_HOT;
    hold_gen(1'b0, 1);
    @(posedge clk) intakeTemp <= 8'sh14;
    hold_gen(1'b0, 355);
    wait_gen(1'b1, 10);
  endtask : t_solo

  task t_combo;
    pb = pc;
    @(posedge clk) unitRun <= 1'b1;
    read_stat();
    check("mode", q[1:0], M_COMBO);
    check("fanSel", fanSel, modeFan);
    check("swingSel", swingSel, modeSwing);
    check("beep", pc[0] - pb[0], 1);
    @(posedge clk) fanRpm <= RPM_MIN - 12'h001;
    wait_gen(1'b0, 1);
    @(posedge clk) fanRpm <= RPM_MIN;
    wait_gen(1'b1, 1);
  endtask : t_combo

  task t_timers;
    pb = pc;
    cmd(3'h4);
    read_stat();
    check("mode", q[1:0], M_OFF);
    check("stopReq", pc[3] - pb[3], 1);
    wait_gen(1'b0, 1);
    @(posedge clk) unitRun <= 1'b0;
    cmd(3'h2);
    read_stat();
    check("mode", q[1:0], M_COMBO);
    @(posedge clk) unitRun <= 1'b1;
    cmd(3'h2);
    read_stat();
    check("mode", q[1:0], M_COMBO);
    check("startReq", pc[2] - pb[2], 1);
  endtask : t_timers

  task t_beeps;
    pb = pc;
    cmd(3'h1);
    read_stat();
    check("mode", q[1:0], M_OFF);
    @(posedge clk) unitRun <= 1'b0;
    cmd(3'h1);
    cmd(3'h1);
    check("beepShort", pc[0] - pb[0], 2);
    check("beepLong", pc[1] - pb[1], 1);
    cmd(3'h1);
    @(posedge clk) unitRun <= 1'b1;
    repeat (3) @(posedge clk);
    unitRun <= 1'b0;
    read_stat();
    check("mode", q[1:0], M_OFF);
  endtask : t_beeps

  task t_disc;
    // open lead before power-up so the abnormal run starts with the window
    @(posedge clk) breakWire <= 1'b1;
    cmd(3'h1);
    wait_gen(1'b1, 1);
    hold_gen(1'b1, 5);
    wait_gen(1'b0, 3);
    read_stat();
    check("discCnt", q[6:4], 3'h2);
    cmd(3'h1);
    read_stat();
    check("discCnt", q[6:5], 2'h0);
    cmd(3'h1);
    wait_gen(1'b1, 310);
    pb = pc;
    for (int i = 0; i < 3; i++) begin
      wait_gen(1'b0, 8);
      if (i < 2) begin
        hold_gen(1'b0, 290);
        wait_gen(1'b1, 20);
      end
    end
    read_stat();
    check("discFault", q[6:4], 3'h7);
    check("ionIndicator", ionIndicator, 1'b0);
    check("blink", blink, 1'b0);
    check("nvmWrite", pc[4] - pb[4], 1);
    check("nvmHidden", lastHidden, 1'b0);
    check("faultCode", faultCode, IONIZER_FAULT_CODE);
  endtask : t_disc

  task t_check;
    rst(M_SOLO);
    check("persistMode", persistMode, M_SOLO);
    pb = pc;
    ahb(1'b1, ADDR_CFG, 32'h1);
    wait_gen(1'b1, 2);
    wait_gen(1'b0, 10);
    read_stat();
    check("discFault", q[4], 1'b1);
    check("blink", blink, 1'b1);
    check("ionIndicator", ionIndicator, 1'b0);
    check("nvmWrite", pc[4] - pb[4], 1);
  endtask : t_check

  task t_disch;
    @(posedge clk) breakWire <= 1'b0;
    rst(M_SOLO);
    wait_gen(1'b1, 2);
    hold_gen(1'b1, 1000);
    @(posedge clk) arcFault <= 1'b1;
    hold_gen(1'b1, 10);
    @(posedge clk) arcFault <= 1'b0;
    hold_gen(1'b1, 791);
    pb = pc;
    @(posedge clk) arcFault <= 1'b1;
    wait_gen(1'b0, 7);
    @(posedge clk) arcFault <= 1'b0;
    read_stat();
    check("dischCnt", q[10:7], 4'h1);
    check("nvmWrite", pc[4] - pb[4], 0);
    hold_gen(1'b0, 60);
    cmd(3'h1);
    read_stat();
    check("dischCnt", q[10:7], 4'h0);
  endtask : t_disch

  initial begin
    resetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; unitRun = 1'b0; fanRun = 1'b1; fanRpm = 12'h3E8;
    intakeTemp = 8'sh14; modeFan = 3'h5; modeSwing = 2'h1; bootMode = M_OFF;
    breakWire = 1'b0; arcFault = 1'b0; n_mismatch = 0; check_count = 0;
    rst(M_OFF);
    t_regs();
    t_solo();
    t_combo();
    t_timers();
    t_beeps();
    t_disc();
    t_check();
    t_disch();
    report_and_stop();
  end
endmodule : ion_fault_ctrl_tb

//--- tb/ion_gen_model.sv
`timescale 1ns/10ps
module ion_gen_model (
  input  wire logic genPower,  // supply from the controller
  input  wire logic breakWire, // emitter lead open
  input  wire logic arcFault,  // discharge runs abnormal
  output logic      abnormalIn // abnormal return, high when faulty
);
  // an unpowered stage reports nothing, so a fault only shows while supplied
  assign abnormalIn = genPower & (breakWire | arcFault);
endmodule : ion_gen_model
